// File: include/ctlst_pkg.sv
/*
 * ctlst_pkg: register map, field positions, reset values and carrier types
 * for the per-port control-channel status and embedded-type tagging block.
 * Assumes an 8-bit register address and 8-bit register data path.
 */
package ctlst_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ERR_CTL    = 8'h46;
    localparam logic [7:0] OFS_STATUS     = 8'h47;
    localparam logic [7:0] OFS_LINK_CAP   = 8'h4A;
    localparam logic [7:0] OFS_EMBED_TAG  = 8'h4B;
    localparam logic [7:0] OFS_PORT_SEL   = 8'h4C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ERR_CTL_ENH_BIT        = 5;
    localparam int STS_SEQ_BIT            = 5;
    localparam int STS_INIT_FAULT_BIT     = 4;
    localparam int STS_INIT_TIMEOUT_BIT   = 3;
    localparam int STS_RESP_FAULT_BIT     = 2;
    localparam int STS_RESP_TIMEOUT_BIT   = 1;
    localparam int STS_ECHO_BIT           = 0;
    localparam int CAP_ENC_CRC_BIT        = 4;
    localparam int TAG_COUNT_MSB          = 7;
    localparam int TAG_COUNT_LSB          = 6;
    localparam int TAG_CODE_MSB           = 5;
    localparam int PSEL_READ_MSB          = 5;
    localparam int PSEL_READ_LSB          = 4;
    localparam int PSEL_WRITE_MSB         = 3;
    localparam int MAX_PORTS              = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic       RST_ENH_ENABLE = 1'b1;
    localparam logic [5:0] RST_STATUS     = 6'h00;
    localparam logic       RST_ENC_CRC    = 1'b0;
    localparam logic [7:0] RST_EMBED_TAG  = 8'h12;
    localparam logic [1:0] RST_READ_PORT  = 2'h0;
    localparam logic [3:0] RST_WRITE_EN   = 4'h0;
    localparam logic [1:0] LINE_COUNT_MAX = 2'h3;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic seq_fault;
        logic initiator_fault;
        logic initiator_timeout;
        logic responder_fault;
        logic responder_timeout;
        logic echo_mismatch;
        logic enc_crc_error;
    } ctlst_evt_t;

    typedef struct packed {
        logic       frame_start;
        logic       long_pkt;
        logic       csi2_mode;
        logic [5:0] raw_type_code;
    } ctlst_pkt_t;

    typedef struct packed {
        logic       valid;
        logic       embedded;
        logic [5:0] type_code;
    } ctlst_tag_t;

    // a set in the clearing cycle survives the clear
    function automatic logic [5:0] sticky(input logic [5:0] cur, input logic [5:0] set, input logic clr);
        sticky = (cur & ~{6{clr}}) | set;
    endfunction : sticky

endpackage : ctlst_pkg

// File: rtl/ctlst_embed_tag.sv
/*
 * ctlst_embed_tag: tags the first long packets of each frame on one receive
 * port with the embedded data type. Assumes frame_start precedes the first
 * long packet of a frame or coincides with it.
 */
`timescale 1ns/1ps

module ctlst_embed_tag (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // packet stream
    input  wire ctlst_pkg::ctlst_pkt_t pkt,
    // settings
    input  wire logic [1:0]            line_count,
    input  wire logic [5:0]            type_code,
    // tagged result
    output ctlst_pkg::ctlst_tag_t      tag_ff
);

    logic [1:0]            cnt_ff;
    logic [1:0]            nxt_cnt;
    ctlst_pkg::ctlst_tag_t nxt_tag;
    logic [1:0]            base;
    logic                  emb;

    // ------------------------------------------------------------------
    // packet counting and tagging
    // ------------------------------------------------------------------
    always_comb begin
        base = pkt.frame_start ? 2'h0 : cnt_ff;
        emb  = pkt.long_pkt && !pkt.csi2_mode && (line_count != 2'h0) && (base < line_count);
        nxt_cnt = base;
        if (pkt.long_pkt && base != ctlst_pkg::LINE_COUNT_MAX) begin
            nxt_cnt = base + 2'h1;
        end
        nxt_tag.valid     = pkt.long_pkt;
        nxt_tag.embedded  = emb;
        nxt_tag.type_code = emb ? type_code : pkt.raw_type_code;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 2'h0;
            tag_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            tag_ff <= nxt_tag;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_first_raw_pkt;
        pkt.long_pkt && pkt.frame_start && !pkt.csi2_mode && line_count != 2'h0;
    endsequence

    first_line_tag_a: assert property (s_first_raw_pkt |=> tag_ff.valid && tag_ff.embedded
        && tag_ff.type_code == $past(type_code)) else $error("first line not tagged");
    raw_passthru_a: assert property (pkt.long_pkt && line_count == 2'h0 |=> !tag_ff.embedded
        && tag_ff.type_code == $past(pkt.raw_type_code)) else $error("raw packet retagged");
    csi2_untouched_a: assert property (pkt.long_pkt && pkt.csi2_mode |=> !tag_ff.embedded)
        else $error("csi2 packet retagged");
    single_line_a: assert property ((s_first_raw_pkt and line_count == 2'h1) ##1
        (pkt.long_pkt && !pkt.frame_start && line_count == 2'h1) |=> !tag_ff.embedded)
        else $error("second line tagged with count one");

endmodule : ctlst_embed_tag

// File: rtl/ctlst_top.sv
/*
 * ctlst_top: per-receive-port control-channel fault status, link capability
 * and embedded-type tagging registers, steered by a port-select register.
 * Assumes a byte register port driven by the device's I2C target logic,
 * event pulses from the control-channel engine, and one packet stream per port.
 */
// Summary of operation
// - sequence error on forward control channel sets status bit 5
// - enhanced checking off: bit 5 mirrors receive port status one sequence bit
// - enhanced checking on: bit 5 held locally, cleared by status read
// - initiator-side sequence/CRC/lock error sets bit 4; clear on read; enhanced only
// - initiator-side watchdog expiry sets bit 3; clear on read; enhanced only
// - responder-side sequence/CRC/lock error sets bit 2; clear on read; enhanced only
// - responder-side watchdog expiry sets bit 1; clear on read
// - serializer echoes data; mismatch sets bit 0; clear on read; enhanced only
// - capability bit 4 enables flagging of encoder CRC errors
// - encoder CRC flagging also needs the encoder CRC disable input low
// - tag line count zero: every long packet forwarded as raw video
// - tag line count 1..3: first that many long packets per frame embedded
// - embedded packets carry the 6-bit embedded type code, reset 0x12
// - tagging has no effect when the port receives CSI-2 formatted data
// - port-select register gives read-port selector and per-port write enables
// - error control bit 5 enables enhanced checking, reset enabled
`timescale 1ns/1ps

module ctlst_top #(
    parameter int NPORT = 4
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              nrst,
    // register access
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic [7:0]                        reg_wdata,
    output logic [7:0]                             reg_rdata_ff,
    // control channel events
    input  wire ctlst_pkg::ctlst_evt_t [NPORT-1:0] evt,
    input  wire logic [NPORT-1:0]                  rx_sts1_seq_fault,
    input  wire logic                              encoder_crc_disable,
    output logic [NPORT-1:0]                       enc_crc_flag_ff,
    // packet path
    input  wire ctlst_pkg::ctlst_pkt_t [NPORT-1:0] pkt,
    output ctlst_pkg::ctlst_tag_t [NPORT-1:0]      tag_ff
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (NPORT < 1 || NPORT > ctlst_pkg::MAX_PORTS) begin : g_bad_nport
        $error("NPORT must lie between 1 and 4");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [1:0]             rd_port_ff;
    logic [1:0]             nxt_rd_port;
    logic [3:0]             wr_en_ff;
    logic [3:0]             nxt_wr_en;
    logic [NPORT-1:0]       enh_ff;
    logic [NPORT-1:0]       nxt_enh;
    logic [NPORT-1:0][5:0]  flags_ff;
    logic [NPORT-1:0][5:0]  nxt_flags;
    logic [NPORT-1:0][5:0]  set_vec;
    logic [NPORT-1:0]       clr_vec;
    logic [NPORT-1:0]       cap_ff;
    logic [NPORT-1:0]       nxt_cap;
    logic [NPORT-1:0][7:0]  embed_ff;
    logic [NPORT-1:0][7:0]  nxt_embed;
    logic [NPORT-1:0]       nxt_enc_crc;
    logic [7:0]             nxt_rdata;
    logic                   hit_status;

    // ------------------------------------------------------------------
    // port select register
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rd_port = rd_port_ff;
        nxt_wr_en   = wr_en_ff;
        if (reg_wr && reg_addr == ctlst_pkg::OFS_PORT_SEL) begin
            nxt_rd_port = reg_wdata[ctlst_pkg::PSEL_READ_MSB:ctlst_pkg::PSEL_READ_LSB];
            nxt_wr_en   = reg_wdata[ctlst_pkg::PSEL_WRITE_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_port_ff <= ctlst_pkg::RST_READ_PORT;
            wr_en_ff   <= ctlst_pkg::RST_WRITE_EN;
        end else begin
            rd_port_ff <= nxt_rd_port;
            wr_en_ff   <= nxt_wr_en;
        end
    end

    // ------------------------------------------------------------------
    // per-port registers and status flags
    // ------------------------------------------------------------------
    // writes broadcast to every enabled port; reads and clears hit one port
    assign hit_status = reg_rd && reg_addr == ctlst_pkg::OFS_STATUS;

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            nxt_enh[p]   = enh_ff[p];
            nxt_cap[p]   = cap_ff[p];
            nxt_embed[p] = embed_ff[p];
            if (reg_wr && wr_en_ff[p]) begin
                if (reg_addr == ctlst_pkg::OFS_ERR_CTL) begin
                    nxt_enh[p] = reg_wdata[ctlst_pkg::ERR_CTL_ENH_BIT];
                end
                if (reg_addr == ctlst_pkg::OFS_LINK_CAP) begin
                    nxt_cap[p] = reg_wdata[ctlst_pkg::CAP_ENC_CRC_BIT];
                end
                if (reg_addr == ctlst_pkg::OFS_EMBED_TAG) begin
                    nxt_embed[p] = reg_wdata;
                end
            end
            clr_vec[p] = hit_status && rd_port_ff == 2'(p);
            set_vec[p] = '0;
            set_vec[p][ctlst_pkg::STS_SEQ_BIT]          = evt[p].seq_fault && enh_ff[p];
            set_vec[p][ctlst_pkg::STS_INIT_FAULT_BIT]   = evt[p].initiator_fault && enh_ff[p];
            set_vec[p][ctlst_pkg::STS_INIT_TIMEOUT_BIT] = evt[p].initiator_timeout && enh_ff[p];
            set_vec[p][ctlst_pkg::STS_RESP_FAULT_BIT]   = evt[p].responder_fault && enh_ff[p];
            set_vec[p][ctlst_pkg::STS_RESP_TIMEOUT_BIT] = evt[p].responder_timeout;
            set_vec[p][ctlst_pkg::STS_ECHO_BIT]         = evt[p].echo_mismatch && enh_ff[p];
            nxt_flags[p] = ctlst_pkg::sticky(flags_ff[p], set_vec[p], clr_vec[p]);
            // the encoder CRC report is a pulse to the error counters downstream
            nxt_enc_crc[p] = evt[p].enc_crc_error && cap_ff[p] && !encoder_crc_disable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < NPORT; p++) begin
                enh_ff[p]          <= ctlst_pkg::RST_ENH_ENABLE;
                flags_ff[p]        <= ctlst_pkg::RST_STATUS;
                cap_ff[p]          <= 1'b0;
                embed_ff[p]        <= ctlst_pkg::RST_EMBED_TAG;
                enc_crc_flag_ff[p] <= ctlst_pkg::RST_ENC_CRC;
            end
        end else begin
            enh_ff          <= nxt_enh;
            flags_ff        <= nxt_flags;
            cap_ff          <= nxt_cap;
            embed_ff        <= nxt_embed;
            enc_crc_flag_ff <= nxt_enc_crc;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // unmapped offsets and selected ports NPORT and above read as zero
    always_comb begin
        nxt_rdata = reg_rdata_ff;
        if (reg_rd) begin
            nxt_rdata = 8'h00;
            if (reg_addr == ctlst_pkg::OFS_PORT_SEL) begin
                nxt_rdata = {2'h0, rd_port_ff, wr_en_ff};
            end
            for (int p = 0; p < NPORT; p++) begin
                if (rd_port_ff == 2'(p)) begin
                    case (reg_addr)
                        ctlst_pkg::OFS_ERR_CTL: begin
                            nxt_rdata[ctlst_pkg::ERR_CTL_ENH_BIT] = enh_ff[p];
                        end
                        ctlst_pkg::OFS_STATUS: begin
                            nxt_rdata[4:0] = flags_ff[p][4:0];
                            nxt_rdata[ctlst_pkg::STS_SEQ_BIT] = enh_ff[p] ? flags_ff[p][ctlst_pkg::STS_SEQ_BIT]
                                                                          : rx_sts1_seq_fault[p];
                        end
                        ctlst_pkg::OFS_LINK_CAP: begin
                            nxt_rdata[ctlst_pkg::CAP_ENC_CRC_BIT] = cap_ff[p];
                        end
                        ctlst_pkg::OFS_EMBED_TAG: begin
                            nxt_rdata = embed_ff[p];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // embedded type tagging per port
    // ------------------------------------------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : g_tag
        ctlst_embed_tag u_tag (
            .clk        (clk),
            .nrst       (nrst),
            .pkt        (pkt[p]),
            .line_count (embed_ff[p][ctlst_pkg::TAG_COUNT_MSB:ctlst_pkg::TAG_COUNT_LSB]),
            .type_code  (embed_ff[p][ctlst_pkg::TAG_CODE_MSB:0]),
            .tag_ff     (tag_ff[p])
        );
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_status_read(int p);
        hit_status && rd_port_ff == 2'(p);
    endsequence

    portsel_write_a: assert property (reg_wr && reg_addr == ctlst_pkg::OFS_PORT_SEL |=>
        wr_en_ff == $past(reg_wdata[3:0]) && rd_port_ff == $past(reg_wdata[5:4]))
        else $error("port select not loaded");

    for (genvar p = 0; p < NPORT; p++) begin : g_chk
        seq_mirror_a: assert property (s_status_read(p) and !enh_ff[p] |=>
            reg_rdata_ff[5] == $past(rx_sts1_seq_fault[p])) else $error("sequence bit not mirrored");
        seq_clear_a: assert property (s_status_read(p) ##0 enh_ff[p] && !evt[p].seq_fault
            |=> !flags_ff[p][5]) else $error("sequence bit not cleared by read");
        seq_set_a: assert property (evt[p].seq_fault && enh_ff[p] |=> flags_ff[p][5] ##1
            (flags_ff[p][5] || $past(clr_vec[p]))) else $error("sequence fault lost");
        init_gate_a: assert property (!enh_ff[p] && !flags_ff[p][4] |=> !flags_ff[p][4])
            else $error("initiator fault set with enhanced checking off");
        init_to_a: assert property (evt[p].initiator_timeout && enh_ff[p] |=> flags_ff[p][3])
            else $error("initiator timeout lost");
        resp_fault_a: assert property (evt[p].responder_fault && enh_ff[p] |=> flags_ff[p][2])
            else $error("responder fault lost");
        resp_to_a: assert property (evt[p].responder_timeout |=> flags_ff[p][1])
            else $error("responder timeout lost");
        echo_gate_a: assert property (!enh_ff[p] && !flags_ff[p][0] |=> !flags_ff[p][0])
            else $error("echo mismatch set with enhanced checking off");
        hold_flag_a: assert property (flags_ff[p][1] && !clr_vec[p] |=> flags_ff[p][1])
            else $error("flag dropped without read");
        set_wins_a: assert property (clr_vec[p] && evt[p].responder_timeout |=> flags_ff[p][1])
            else $error("event lost in clearing read");
        enc_crc_a: assert property (enc_crc_flag_ff[p] |-> $past(cap_ff[p]) &&
            !$past(encoder_crc_disable) && $past(evt[p].enc_crc_error)) else $error("encoder crc flag unqualified");
        write_gate_a: assert property (reg_wr && !wr_en_ff[p] |=> $stable(embed_ff[p]) && $stable(cap_ff[p]))
            else $error("write reached disabled port");
    end

endmodule : ctlst_top

// File: tb/ctlst_peer.sv
/*
 * ctlst_peer: remote serializer stand-in; issues control channel event
 * pulses and raw packet streams toward the hub's four receive ports.
 * Assumes the bench calls its tasks one at a time per stream.
 */
`timescale 1ns/1ps

module ctlst_peer (
    // clock
    input  wire logic                   clk,
    // streams toward the hub
    output ctlst_pkg::ctlst_evt_t [3:0] evt,
    output ctlst_pkg::ctlst_pkt_t [3:0] pkt
);
    initial begin
        evt = '0;
        pkt = '0;
    end

    // ------------------------------------------------------------------
    // control channel
    // ------------------------------------------------------------------
    // one-cycle pulse, launched 1 ns after an edge so sampling never races
    task automatic fire(input int p, input int b);
        @(posedge clk);
        #1;
        evt[p] = ctlst_pkg::ctlst_evt_t'(7'h01 << b);
        @(posedge clk);
        #1;
        evt = '0;
    endtask : fire

    // the returned byte may be corrupted on the wire; a difference is flagged
    task automatic echo(input int p, input logic [7:0] sent, input logic [7:0] back);
        if (sent !== back) begin
            fire(p, 1);
        end
    endtask : echo

    // ------------------------------------------------------------------
    // packet stream
    // ------------------------------------------------------------------
    // no edge wait before launch, so calls in a row give packets on consecutive edges
    task automatic send(input int p, input logic fs, input logic csi2, input logic [5:0] raw);
        #1;
        pkt[p] = '{frame_start: fs, long_pkt: 1'b1, csi2_mode: csi2, raw_type_code: raw};
        @(posedge clk);
        #1;
        pkt = '0;
    endtask : send
endmodule : ctlst_peer

// File: tb/tb_top.sv
/*
 * tb_top: register-level bench for the control channel status and tagging block.
 * Assumes the one-cycle strobe register port and registered read data.
 */
`timescale 1ns/1ps

module tb_top;
    logic                             clk = 1'b0;
    logic                             nrst = 1'b0;
    logic                             reg_wr = 1'b0;
    logic                             reg_rd = 1'b0;
    logic [7:0]                       reg_addr = 8'h00;
    logic [7:0]                       reg_wdata = 8'h00;
    logic [7:0]                       reg_rdata_ff;
    logic [3:0]                       rx_sts1_seq_fault = 4'h0;
    logic                             encoder_crc_disable = 1'b0;
    logic [3:0]                       enc_crc_flag_ff;
    ctlst_pkg::ctlst_evt_t [3:0]      evt;
    ctlst_pkg::ctlst_pkt_t [3:0]      pkt;
    ctlst_pkg::ctlst_tag_t [3:0]      tag_ff;
    int                               n_errors = 0;
    int                               samples_checked = 0;
    int                               cycles = 0;

    always #2.5 clk = ~clk;

    ctlst_peer peer_u (.clk(clk), .evt(evt), .pkt(pkt));

    ctlst_top #(.NPORT(4)) dut_u (
        .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .evt(evt),
        .rx_sts1_seq_fault(rx_sts1_seq_fault), .encoder_crc_disable(encoder_crc_disable),
        .enc_crc_flag_ff(enc_crc_flag_ff), .pkt(pkt), .tag_ff(tag_ff)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        check("register", exp, reg_rdata_ff);
    endtask : rd

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // a hang is cut short well past the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        rd(8'h47, 8'h00);
        rd(8'h4A, 8'h00);
        rd(8'h4B, 8'h12);
        rd(8'h46, 8'h20);
        rd(8'h4C, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h4C, 8'h0F);
        // each flag holds until read, then clears
        for (int s = 0; s < 6; s++) begin
            peer_u.fire(0, s + 1);
            repeat (10) @(posedge clk);
            rd(8'h47, 8'h01 << s);
            rd(8'h47, 8'h00);
        end
        // an event in the clearing read cycle must survive
        fork
            rd(8'h47, 8'h00);
            peer_u.fire(0, 2);
        join
        rd(8'h47, 8'h02);
        // echo corruption on port 2, read through the selector
        wr(8'h4C, 8'h20);
        peer_u.echo(2, 8'hA5, 8'hA4);
        rd(8'h47, 8'h01);
        peer_u.echo(2, 8'hA5, 8'hA5);
        rd(8'h47, 8'h00);
        // enhanced checking off: only the responder timeout latches, bit 5 mirrors
        wr(8'h4C, 8'h0F);
        wr(8'h46, 8'h00);
        rd(8'h46, 8'h00);
        for (int b = 1; b < 7; b++) begin
            peer_u.fire(0, b);
        end
        rd(8'h47, 8'h02);
        rx_sts1_seq_fault = 4'h1;
        rd(8'h47, 8'h20);
        rx_sts1_seq_fault = 4'h0;
        rd(8'h47, 8'h00);
        wr(8'h46, 8'h20);
        // encoder crc flagging needs capability set and disable low
        for (int k = 0; k < 3; k++) begin
            wr(8'h4A, (k == 0) ? 8'h00 : 8'h10);
            encoder_crc_disable = (k == 2);
            peer_u.fire(0, 0);
            check("enc_crc", {7'h00, k == 1}, {7'h00, enc_crc_flag_ff[0]});
        end
        rd(8'h4A, 8'h10);
        encoder_crc_disable = 1'b0;
        // write enables steer per-port writes
        wr(8'h4C, 8'h02);
        wr(8'h4B, 8'hC5);
        wr(8'h4C, 8'h10);
        wr(8'h4B, 8'h00);
        rd(8'h4B, 8'hC5);
        wr(8'h4C, 8'h00);
        rd(8'h4B, 8'h12);
        // tagging for every line count, then a csi-2 frame
        wr(8'h4C, 8'h01);
        for (int c = 0; c < 5; c++) begin
            wr(8'h4B, {2'((c > 3) ? 3 : c), 6'h15});
            for (int i = 0; i < 4; i++) begin
                peer_u.send(0, i == 0, c == 4, 6'h2B);
                check("tag", (i < c && c < 4) ? 8'hD5 : 8'hAB, tag_ff[0]);
            end
        end
        tally_and_finish();
    end
endmodule : tb_top
